// >>> verilog/hfp_pkg.sv
// constants and carrier types for the field bus frame poller
// assumes a 200 mhz clock and a byte-wide modem on the same clock
package hfp_pkg;
  // frame layout
  localparam logic [7:0] HFP_PREAMBLE = 8'hff;
  localparam logic [4:0] HFP_PRE_MIN = 5'h05;
  localparam logic [4:0] HFP_PRE_MAX = 5'h14;
  localparam int HFP_DLM_LONG = 7;
  localparam logic [2:0] HFP_TYPE_BURST = 3'h1;
  localparam logic [2:0] HFP_TYPE_MASTER = 3'h2;
  localparam logic [2:0] HFP_TYPE_SLAVE = 3'h6;
  localparam logic [8:0] HFP_ALEN_SHORT = 9'h001;
  localparam logic [8:0] HFP_ALEN_LONG = 9'h005;
  localparam logic [8:0] HFP_REL_CMD = 9'h001;
  localparam logic [8:0] HFP_REL_BC = 9'h002;
  localparam logic [8:0] HFP_REL_DATA = 9'h003;
  localparam logic [7:0] HFP_ADDR_PRIMARY = 8'h80;
  // command number classes
  localparam logic [7:0] HFP_UNIV_LAST = 8'h1e;
  localparam logic [7:0] HFP_RSV_A = 8'h1f;
  localparam logic [7:0] HFP_CP_LAST = 8'h7e;
  localparam logic [7:0] HFP_RSV_B = 8'h7f;
  localparam logic [7:0] HFP_TS_LAST = 8'hfd;
  // response code
  localparam logic [7:0] HFP_RSP_LEN = 8'h02;
  localparam int HFP_RSP_COMM = 7;
  localparam logic [6:0] HFP_RC_OK = 7'h00;
  localparam logic [6:0] HFP_RC_INVSEL = 7'h02;
  localparam logic [6:0] HFP_RC_BIG = 7'h03;
  localparam logic [6:0] HFP_RC_SMALL = 7'h04;
  localparam logic [6:0] HFP_RC_FEW = 7'h05;
  localparam logic [6:0] HFP_RC_WPROT = 7'h07;
  localparam logic [6:0] HFP_RC_RESTR = 7'h10;
  localparam logic [6:0] HFP_RC_BUSY = 7'h20;
  localparam logic [6:0] HFP_RC_NOIMP = 7'h40;
  // timing
  localparam int HFP_CLK_NS = 5;
  localparam int HFP_MS_NS = 1000000;
  localparam int HFP_MS_CYC = (HFP_MS_NS + HFP_CLK_NS - 1) / HFP_CLK_NS;
  localparam logic [15:0] HFP_FLASH_HALF_MS = 16'h01f4;

  typedef enum logic [2:0] {
    HFP_SQ_GAP = 3'b001, HFP_SQ_TX = 3'b010, HFP_SQ_WAIT = 3'b100
  } hfp_seq_e;
  typedef enum logic [5:0] {
    HFP_RX_HUNT = 6'b000001, HFP_RX_ADDR = 6'b000010,
    HFP_RX_CMD = 6'b000100, HFP_RX_CNT = 6'b001000,
    HFP_RX_BODY = 6'b010000, HFP_RX_CHK = 6'b100000
  } hfp_rx_e;
  typedef enum logic [1:0] {
    HFP_CLS_UNIV = 2'h0, HFP_CLS_COMMON = 2'h1,
    HFP_CLS_SPEC = 2'h2, HFP_CLS_RSVD = 2'h3
  } hfp_class_e;

  typedef struct packed {
    logic autoPoll;
    logic [7:0] numInit;
    logic [7:0] numPoll;
    logic [15:0] intervalMs;
    logic [15:0] timeoutMs;
    logic [2:0] retryCount;
    logic [4:0] preambleCount;
  } hfp_cfg_s;
  typedef struct packed {
    logic longFmt;
    logic [3:0] pollAddr;
    logic [39:0] longAddr;
    logic [7:0] cmd;
    logic [7:0] dataLen;
  } hfp_cmd_s;
  typedef struct packed {
    logic commErr, parity, overrun, framing;
    logic checksum, rsvd, rxOverflow, undef;
  } hfp_cerr_s;
  typedef struct packed {
    logic malfunction, cfgChanged, coldStart, moreStatus;
    logic curFixed, outSat, svLimit, pvLimit;
  } hfp_fstat_s;
  typedef struct packed {
    logic initPhase;
    logic [7:0] index;
    logic [7:0] command;
    hfp_class_e cls;
    logic fail;
    hfp_cerr_s cerr;
    logic [6:0] code;
    logic codeKnown;
    hfp_fstat_s fstat;
    logic statusViol;
  } hfp_res_s;
endpackage

// >>> verilog/hfp_frame_poller.sv
// master-side frame builder, reply parser and poll sequencer
// assumes modem byte ports and command tables sit on the same clock
// How it works
// - frames open with 5 to 20 preamble bytes of 0xff
// - requests go preamble, delimiter, address, command, count, data, check
// - delimiter carries long/short bit and master/slave/burst type
// - short address is one byte, long address five bytes
// - command numbers are sorted into universal, common, specific, reserved
// - byte count covers everything between it and the check byte
// - first byte bit 7 set means bit-mapped comm error flags
// - first byte bit 7 clear means integer command response code
// - second byte holds eight field status flags
// - data length and meaning follow only the command number
// - every frame ends in a check byte; bad ones count as errors
// - after reset run the initial phase, then the operating phase
// - initial phase sends every init command, run light flashes
// - operating phase polls every command, run light steady
// - automatic polling only while the auto poll setting is on
// - short addresses are 0 for point-to-point, 1 to 15 multi-drop
`timescale 1ns/1ps
module hfp_frame_poller #(
  parameter int MS_CYCLES = hfp_pkg::HFP_MS_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire hfp_pkg::hfp_cfg_s cfg,
  output logic cmdInit,
  output logic [7:0] cmdSel,
  input wire hfp_pkg::hfp_cmd_s cmdEntry,
  output logic [7:0] dataSel,
  input wire logic [7:0] dataByte,
  output logic txValid,
  output logic [7:0] txByte,
  input wire logic txReady,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxError,
  output logic rxDataValid,
  output logic [7:0] rxDataByte,
  output logic resultValid,
  output hfp_pkg::hfp_res_s result,
  output logic runLed,
  output logic operating
);
  import hfp_pkg::*;
  localparam int DW = $clog2(MS_CYCLES + 1);

  function automatic hfp_class_e cmdClass(input logic [7:0] c);
    if (c <= HFP_UNIV_LAST) return HFP_CLS_UNIV;
    if (c == HFP_RSV_A || c == HFP_RSV_B || c > HFP_TS_LAST)
      return HFP_CLS_RSVD;
    if (c <= HFP_CP_LAST) return HFP_CLS_COMMON;
    return HFP_CLS_SPEC;
  endfunction

  logic [DW-1:0] divCnt_r, divCnt_nxt;
  logic msTick_r, msTick_nxt, flash_r, flash_nxt, led_r, led_nxt;
  logic [15:0] flashCnt_r, flashCnt_nxt;
  hfp_rx_e rx_r, rx_nxt;
  logic [7:0] rxCnt_r, rxCnt_nxt, rxBc_r, rxBc_nxt, rxChk_r, rxChk_nxt;
  logic [7:0] rxCmd_r, rxCmd_nxt, rsp0_r, rsp0_nxt, rsp1_r, rsp1_nxt;
  logic [7:0] rxDb_r, rxDb_nxt;
  logic [2:0] rxType_r, rxType_nxt;
  logic rxLong_r, rxLong_nxt, rxBad_r, rxBad_nxt, rxDv_r, rxDv_nxt;
  logic rxDone_r, rxDone_nxt, rxOk_r, rxOk_nxt;
  hfp_seq_e sq_r, sq_nxt;
  logic initPhase_r, initPhase_nxt, txValid_r, txValid_nxt;
  logic [7:0] idx_r, idx_nxt, txByte_r, txByte_nxt, chk_r, chk_nxt;
  logic [2:0] tries_r, tries_nxt;
  logic [15:0] msCnt_r, msCnt_nxt;
  logic [8:0] txPos_r, txPos_nxt;
  hfp_res_s res_r, res_nxt;
  logic resV_r, resV_nxt;
  logic [4:0] preClamp;
  logic [8:0] preN, aLen, rel, lastPos;
  logic [39:0] shAddr;
  logic [7:0] txNext, count;
  logic load, good, bad, finish, failNow;

  // millisecond divider and run light
  always_comb begin
    divCnt_nxt = divCnt_r + 1'b1;
    msTick_nxt = 1'b0;
    if (divCnt_r == DW'(MS_CYCLES - 1)) begin
      divCnt_nxt = '0;
      msTick_nxt = 1'b1;
    end
    flashCnt_nxt = flashCnt_r;
    flash_nxt = flash_r;
    if (msTick_r) begin
      flashCnt_nxt = flashCnt_r + 16'h0001;
      if (flashCnt_nxt == HFP_FLASH_HALF_MS) begin
        flashCnt_nxt = '0;
        flash_nxt = !flash_r;
      end
    end
    led_nxt = initPhase_r ? flash_r : 1'b1;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      divCnt_r <= '0;
      msTick_r <= 1'b0;
      flashCnt_r <= '0;
      flash_r <= 1'b0;
      led_r <= 1'b0;
    end else begin
      divCnt_r <= divCnt_nxt;
      msTick_r <= msTick_nxt;
      flashCnt_r <= flashCnt_nxt;
      flash_r <= flash_nxt;
      led_r <= led_nxt;
    end
  end

  // reply parser: hunt delimiter, walk fields, check xor
  always_comb begin
    rx_nxt = rx_r;
    rxCnt_nxt = rxCnt_r;
    rxBc_nxt = rxBc_r;
    rxChk_nxt = rxChk_r;
    rxCmd_nxt = rxCmd_r;
    rsp0_nxt = rsp0_r;
    rsp1_nxt = rsp1_r;
    rxDb_nxt = rxDb_r;
    rxType_nxt = rxType_r;
    rxLong_nxt = rxLong_r;
    rxBad_nxt = rxBad_r;
    rxDv_nxt = 1'b0;
    rxDone_nxt = 1'b0;
    rxOk_nxt = rxOk_r;
    if (rxValid) begin
      rxChk_nxt = rxChk_r ^ rxByte;
      rxBad_nxt = rxBad_r | rxError;
      case (rx_r)
        HFP_RX_HUNT: begin
          if (rxByte != HFP_PREAMBLE) begin
            rxChk_nxt = rxByte;
            rxLong_nxt = rxByte[HFP_DLM_LONG];
            rxType_nxt = rxByte[2:0];
            rxBad_nxt = rxError;
            rxCnt_nxt = '0;
            rx_nxt = HFP_RX_ADDR;
          end
        end
        HFP_RX_ADDR: begin
          rxCnt_nxt = rxCnt_r + 8'h01;
          if ({1'b0, rxCnt_nxt} == (rxLong_r ? HFP_ALEN_LONG
                                             : HFP_ALEN_SHORT))
            rx_nxt = HFP_RX_CMD;
        end
        HFP_RX_CMD: begin
          rxCmd_nxt = rxByte;
          rx_nxt = HFP_RX_CNT;
        end
        HFP_RX_CNT: begin
          rxBc_nxt = rxByte;
          rxCnt_nxt = '0;
          rx_nxt = (rxByte == '0) ? HFP_RX_CHK : HFP_RX_BODY;
        end
        HFP_RX_BODY: begin
          if (rxCnt_r == '0) rsp0_nxt = rxByte;
          else if (rxCnt_r == 8'h01) rsp1_nxt = rxByte;
          else begin
            rxDv_nxt = 1'b1;
            rxDb_nxt = rxByte;
          end
          rxCnt_nxt = rxCnt_r + 8'h01;
          if (rxCnt_nxt == rxBc_r) rx_nxt = HFP_RX_CHK;
        end
        HFP_RX_CHK: begin
          rxDone_nxt = 1'b1;
          rxOk_nxt = !rxBad_nxt && rxChk_r == rxByte
                     && rxType_r == HFP_TYPE_SLAVE
                     && rxBc_r >= HFP_RSP_LEN;
          rx_nxt = HFP_RX_HUNT;
        end
        default: rx_nxt = HFP_RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_r <= HFP_RX_HUNT;
      {rxCnt_r, rxBc_r, rxChk_r, rxCmd_r} <= '0;
      {rsp0_r, rsp1_r, rxDb_r, rxType_r} <= '0;
      {rxLong_r, rxBad_r, rxDv_r, rxDone_r, rxOk_r} <= '0;
    end else begin
      rx_r <= rx_nxt;
      {rxCnt_r, rxBc_r, rxChk_r, rxCmd_r} <=
        {rxCnt_nxt, rxBc_nxt, rxChk_nxt, rxCmd_nxt};
      {rsp0_r, rsp1_r, rxDb_r, rxType_r} <=
        {rsp0_nxt, rsp1_nxt, rxDb_nxt, rxType_nxt};
      {rxLong_r, rxBad_r, rxDv_r, rxDone_r, rxOk_r} <=
        {rxLong_nxt, rxBad_nxt, rxDv_nxt, rxDone_nxt, rxOk_nxt};
    end
  end

  // request byte for the current position
  always_comb begin
    preClamp = cfg.preambleCount;
    if (preClamp < HFP_PRE_MIN) preClamp = HFP_PRE_MIN;
    if (preClamp > HFP_PRE_MAX) preClamp = HFP_PRE_MAX;
    preN = {4'h0, preClamp};
    aLen = cmdEntry.longFmt ? HFP_ALEN_LONG : HFP_ALEN_SHORT;
    lastPos = preN + aLen + HFP_REL_DATA + {1'b0, cmdEntry.dataLen};
    rel = txPos_r - preN;
    dataSel = 8'(rel - aLen - HFP_REL_DATA);
    shAddr = cmdEntry.longAddr >> {aLen - rel, 3'b000};
    if (txPos_r < preN) txNext = HFP_PREAMBLE;
    else if (rel == '0)
      txNext = {cmdEntry.longFmt, 4'h0, HFP_TYPE_MASTER};
    else if (rel <= aLen)
      txNext = cmdEntry.longFmt ? shAddr[7:0]
             : (HFP_ADDR_PRIMARY | {4'h0, cmdEntry.pollAddr});
    else if (rel == aLen + HFP_REL_CMD) txNext = cmdEntry.cmd;
    else if (rel == aLen + HFP_REL_BC) txNext = cmdEntry.dataLen;
    else if (txPos_r < lastPos) txNext = dataByte;
    else txNext = chk_r;
  end

  // poll sequencer and transmit path
  always_comb begin
    sq_nxt = sq_r;
    initPhase_nxt = initPhase_r;
    idx_nxt = idx_r;
    tries_nxt = tries_r;
    msCnt_nxt = msCnt_r;
    if (msTick_r && msCnt_r != 16'hffff) msCnt_nxt = msCnt_r + 16'h0001;
    txPos_nxt = txPos_r;
    chk_nxt = chk_r;
    txByte_nxt = txByte_r;
    txValid_nxt = txValid_r && !txReady;
    resV_nxt = 1'b0;
    res_nxt = res_r;
    count = initPhase_r ? cfg.numInit : cfg.numPoll;
    load = sq_r == HFP_SQ_TX && (!txValid_r || txReady)
           && txPos_r <= lastPos;
    good = rxDone_r && rxOk_r && rxCmd_r == cmdEntry.cmd;
    bad = (rxDone_r && !good) || msCnt_r >= cfg.timeoutMs;
    finish = 1'b0;
    failNow = 1'b0;
    case (sq_r)
      HFP_SQ_GAP: begin
        if (initPhase_r && cfg.numInit == '0) begin
          initPhase_nxt = 1'b0;
          idx_nxt = '0;
        end else if (msCnt_r >= cfg.intervalMs
                     && (initPhase_r
                         || (cfg.autoPoll && cfg.numPoll != '0))) begin
          sq_nxt = HFP_SQ_TX;
          txPos_nxt = '0;
          chk_nxt = '0;
        end
      end
      HFP_SQ_TX: begin
        if (load) begin
          txByte_nxt = txNext;
          txValid_nxt = 1'b1;
          txPos_nxt = txPos_r + 9'h001;
          if (txPos_r >= preN && txPos_r != lastPos)
            chk_nxt = chk_r ^ txNext;
        end else if (txPos_r > lastPos && !txValid_r) begin
          sq_nxt = HFP_SQ_WAIT;
          msCnt_nxt = '0;
        end
      end
      HFP_SQ_WAIT: begin
        if (good) finish = 1'b1;
        else if (bad) begin
          if (tries_r < cfg.retryCount) begin
            tries_nxt = tries_r + 3'h1;
            sq_nxt = HFP_SQ_GAP;
            msCnt_nxt = '0;
          end else begin
            finish = 1'b1;
            failNow = 1'b1;
          end
        end
      end
      default: sq_nxt = HFP_SQ_GAP;
    endcase
    if (finish) begin
      resV_nxt = 1'b1;
      res_nxt = '0;
      res_nxt.initPhase = initPhase_r;
      res_nxt.index = idx_r;
      res_nxt.command = cmdEntry.cmd;
      res_nxt.cls = cmdClass(cmdEntry.cmd);
      res_nxt.fail = failNow;
      if (!failNow) begin
        res_nxt.cerr = rsp0_r;
        res_nxt.code = rsp0_r[6:0];
        res_nxt.codeKnown = !rsp0_r[HFP_RSP_COMM] &&
          (rsp0_r[6:0] inside {HFP_RC_OK, HFP_RC_INVSEL, HFP_RC_BIG,
            HFP_RC_SMALL, HFP_RC_FEW, HFP_RC_WPROT, HFP_RC_RESTR,
            HFP_RC_BUSY, HFP_RC_NOIMP});
        res_nxt.fstat = rsp1_r;
        res_nxt.statusViol = rsp0_r[HFP_RSP_COMM] && rsp1_r != '0;
      end
      tries_nxt = '0;
      sq_nxt = HFP_SQ_GAP;
      msCnt_nxt = '0;
      idx_nxt = idx_r + 8'h01;
      if ({1'b0, idx_r} + 9'h001 >= {1'b0, count}) begin
        idx_nxt = '0;
        initPhase_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sq_r <= HFP_SQ_GAP;
      initPhase_r <= 1'b1;
      {idx_r, tries_r, msCnt_r, txPos_r} <= '0;
      {chk_r, txByte_r, txValid_r, resV_r} <= '0;
      res_r <= '0;
    end else begin
      sq_r <= sq_nxt;
      initPhase_r <= initPhase_nxt;
      {idx_r, tries_r, msCnt_r, txPos_r} <=
        {idx_nxt, tries_nxt, msCnt_nxt, txPos_nxt};
      {chk_r, txByte_r, txValid_r, resV_r} <=
        {chk_nxt, txByte_nxt, txValid_nxt, resV_nxt};
      res_r <= res_nxt;
    end
  end

  // outputs
  assign cmdInit = initPhase_r;
  assign cmdSel = idx_r;
  assign txValid = txValid_r;
  assign txByte = txByte_r;
  assign rxDataValid = rxDv_r;
  assign rxDataByte = rxDb_r;
  assign resultValid = resV_r;
  assign result = res_r;
  assign runLed = led_r;
  assign operating = !initPhase_r;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_preamble_byte: assert property (
    load && txPos_r < preN |=> txByte_r == HFP_PREAMBLE)
    else $error("preamble byte not 0xff");
  a_preamble_len: assert property (
    preN >= {4'h0, HFP_PRE_MIN} && preN <= {4'h0, HFP_PRE_MAX})
    else $error("preamble length out of range");
  a_delim_type: assert property (
    load && txPos_r == preN |=> txByte_r[2:0] == HFP_TYPE_MASTER
      && txByte_r[HFP_DLM_LONG] == $past(cmdEntry.longFmt))
    else $error("bad request delimiter");
  a_count_field: assert property (
    load && rel == aLen + HFP_REL_BC |=> txByte_r == $past(cmdEntry.dataLen))
    else $error("byte count mismatch");
  a_check_byte: assert property (
    load && txPos_r == lastPos |=> txByte_r == $past(chk_r))
    else $error("check byte is not the xor");
  a_init_once: assert property (
    !initPhase_r |=> !initPhase_r)
    else $error("returned to initial phase");
  a_led_steady: assert property (
    !initPhase_r ##1 !initPhase_r |-> runLed)
    else $error("run light not steady");
  a_no_autopoll: assert property (
    sq_r == HFP_SQ_GAP && !initPhase_r && !cfg.autoPoll
      |=> sq_r != HFP_SQ_TX)
    else $error("poll sent with auto poll off");
  a_gap_spacing: assert property (
    sq_r == HFP_SQ_GAP ##1 sq_r == HFP_SQ_TX
      |-> $past(msCnt_r) >= $past(cfg.intervalMs))
    else $error("command interval too short");
  a_retry_fail: assert property (
    sq_r == HFP_SQ_WAIT && bad && !good && tries_r >= cfg.retryCount
      |=> resultValid && result.fail)
    else $error("exhausted retries not failed");
  a_comm_zero: assert property (
    resultValid && !result.fail && result.cerr.commErr
      |-> result.statusViol == (result.fstat != '0))
    else $error("status flag check wrong");
  c_enter_op: cover property (initPhase_r ##1 !initPhase_r);
  c_good_reply: cover property (resultValid && !result.fail);
  c_failed_cmd: cover property (resultValid && result.fail);
  c_rx_data: cover property (rxDataValid);
endmodule // hfp_frame_poller

// >>> test/hfp_field_dev.sv
// field instrument model answering poller requests on the byte ports
// assumes the poller's modem ports on one clock; bench sets reply mode
`timescale 1ns/1ps
module hfp_field_dev (
  input wire logic clock,
  input wire logic reset,
  input wire logic txValid,
  input wire logic [7:0] txByte,
  output logic txReady,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic rxError,
  input wire logic [1:0] mode,
  input wire logic [7:0] rc0,
  input wire logic [7:0] rc1,
  input wire logic [1:0] nData,
  output logic [7:0] reqBuf [0:63],
  output int reqLen,
  output logic reqDone
);
  int pre;
  int alen;
  int cyc;
  logic [7:0] chk;
  logic [7:0] rep [$];
  // append one reply byte and fold it into the check byte
  task automatic put(input logic [7:0] b);
    rep.push_back(b);
    chk ^= b;
  endtask
  // build the reply, then send one byte every other cycle
  task automatic reply();
    rep = {8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    chk = 8'h00;
    put({reqBuf[pre][7], 7'h06});
    for (int i = 1; i <= alen + 1; i++) put(reqBuf[pre + i]);
    put(8'h02 + 8'(nData));
    put(rc0);
    put(rc0[7] ? 8'h00 : rc1);
    for (int i = 0; i < nData; i++) put(8'h5a ^ 8'(i));
    rep.push_back(mode == 2'd2 ? ~chk : chk);
    repeat (3) @(posedge clock);
    foreach (rep[i]) begin
      #1;
      rxValid = 1'b1;
      rxByte = rep[i];
      rxError = mode == 2'd3 && i == 6; // flag one address byte
      @(posedge clock);
      #1;
      rxValid = 1'b0;
      rxError = 1'b0;
      rxByte = ~rep[i]; // released line shows no stale byte
      @(posedge clock);
    end
  endtask
  // collect request bytes, find the frame end, then answer except in mode 1
  initial begin
    txReady = 1'b0;
    rxValid = 1'b0;
    rxByte = 8'h00;
    rxError = 1'b0;
    reqDone = 1'b0;
    reqLen = 0;
    pre = 0;
    cyc = 0;
    forever begin
      @(posedge clock);
      if (reset) begin
        reqLen = 0;
        pre = 0;
      end else if (txValid && txReady) begin
        if (reqLen == pre && txByte == 8'hff) pre++;
        reqBuf[reqLen] = txByte;
        reqLen++;
      end
      alen = (reqLen > pre && reqBuf[pre][7]) ? 5 : 1;
      #1;
      cyc++;
      txReady = (cyc % 3) != 0; // stall one cycle in three
      if (reqLen > pre + alen + 2 &&
          reqLen == pre + alen + 4 + int'(reqBuf[pre + alen + 2])) begin
        txReady = 1'b0;
        reqDone = 1'b1;
        @(posedge clock);
        #1;
        reqDone = 1'b0;
        if (mode != 2'd1) reply();
        reqLen = 0;
        pre = 0;
      end
    end
  end
endmodule // hfp_field_dev

// >>> test/testbench.sv
// self-checking bench for the frame poller against an instrument model
// assumes a 200 mhz clock and a shortened millisecond of MS cycles
`timescale 1ns/1ps
module testbench;
  import hfp_pkg::*;
  localparam int MS = 10;
  logic clock, reset, cmdInit, txValid, txReady, rxValid, rxError;
  logic rxDataValid, resultValid, runLed, operating, reqDone, flashSeen;
  logic expInit, inFrame;
  logic [7:0] cmdSel, dataSel, dataByte, txByte, rxByte, rxDataByte;
  logic [7:0] rc0, rc1;
  logic [1:0] mode, nData;
  logic [7:0] reqBuf [0:63];
  hfp_cfg_s cfg;
  hfp_cmd_s cmdEntry;
  hfp_res_s result;
  hfp_cmd_s initTab [0:7];
  hfp_cmd_s pollTab [0:7];
  int reqLen, errorCnt, nChecks, frames, dCnt, cyc, lastEnd, preExp;
  int expIdx, seed;
  logic [7:0] cmds [0:8] = '{8'h1e, 8'h1f, 8'h20, 8'h7e, 8'h7f, 8'h80,
                             8'hfd, 8'hfe, 8'hff};
  logic [7:0] codes [0:10] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07,
                               8'h10, 8'h20, 8'h40, 8'h01, 8'hb8};
  // command tables looked up by the poller's selects
  assign cmdEntry = cmdInit ? initTab[cmdSel[2:0]] : pollTab[cmdSel[2:0]];
  assign dataByte = cmdEntry.cmd ^ dataSel ^ 8'h3c;

  hfp_frame_poller #(.MS_CYCLES(MS)) hfp_frame_poller_i (
    .clock(clock), .reset(reset), .cfg(cfg), .cmdInit(cmdInit),
    .cmdSel(cmdSel), .cmdEntry(cmdEntry), .dataSel(dataSel),
    .dataByte(dataByte), .txValid(txValid), .txByte(txByte),
    .txReady(txReady), .rxValid(rxValid), .rxByte(rxByte),
    .rxError(rxError), .rxDataValid(rxDataValid), .rxDataByte(rxDataByte),
    .resultValid(resultValid), .result(result), .runLed(runLed),
    .operating(operating));
  hfp_field_dev hfp_field_dev_i (
    .clock(clock), .reset(reset), .txValid(txValid), .txByte(txByte),
    .txReady(txReady), .rxValid(rxValid), .rxByte(rxByte),
    .rxError(rxError), .mode(mode), .rc0(rc0), .rc1(rc1), .nData(nData),
    .reqBuf(reqBuf), .reqLen(reqLen), .reqDone(reqDone));

  // clock source
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic testDone();
    if (errorCnt == 0 && nChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask

  function automatic hfp_class_e clsOf(input logic [7:0] c);
    if (c <= 8'h1e) return HFP_CLS_UNIV;
    if (c >= 8'h20 && c <= 8'h7e) return HFP_CLS_COMMON;
    if (c >= 8'h80 && c <= 8'hfd) return HFP_CLS_SPEC;
    return HFP_CLS_RSVD;
  endfunction

  // compare a captured request with the entry being worked on
  task automatic chkFrame();
    hfp_cmd_s e;
    logic [7:0] x;
    int k;
    e = expInit ? initTab[expIdx] : pollTab[expIdx];
    x = 8'h00;
    k = preExp + 1;
    for (int i = 0; i < preExp; i++) check(reqBuf[i], 8'hff);
    check(reqBuf[preExp], {e.longFmt, 7'h02});
    if (e.longFmt) begin
      for (int i = 0; i < 5; i++)
        check(reqBuf[k + i], e.longAddr[39 - 8 * i -: 8]);
      k += 5;
    end else begin
      check(reqBuf[k], {4'h8, e.pollAddr});
      k++;
    end
    check(reqBuf[k], e.cmd);
    check(reqBuf[k + 1], e.dataLen);
    for (int i = 0; i < e.dataLen; i++)
      check(reqBuf[k + 2 + i], e.cmd ^ 8'(i) ^ 8'h3c);
    k += 2 + e.dataLen;
    for (int i = preExp; i < k; i++) x ^= reqBuf[i];
    check(reqBuf[k], x);
    check(reqLen, k + 1);
  endtask

  // frame capture, request spacing, flash watch and run ceiling
  always @(negedge clock) begin
    cyc++;
    if (runLed === 1'b1 && operating === 1'b0) flashSeen = 1'b1;
    if (txValid === 1'b1 && !inFrame) begin
      check(cyc - lastEnd >= (cfg.intervalMs - 1) * MS, 1'b1);
      inFrame = 1'b1;
    end
    if (reqDone === 1'b1) begin
      chkFrame();
      frames++;
      lastEnd = cyc;
      inFrame = 1'b0;
      dCnt = 0;
    end
    if (rxDataValid === 1'b1) begin
      check(rxDataByte, 8'h5a ^ 8'(dCnt));
      dCnt++;
    end
    if (cyc == 40000) begin
      errorCnt++;
      testDone();
    end
  end

  // set the reply for one command and check its result
  task automatic runCmd(input logic ini, input int idx,
                        input logic [1:0] md, input logic [7:0] r0);
    hfp_cmd_s e;
    hfp_res_s x;
    int t;
    e = ini ? initTab[idx] : pollTab[idx];
    mode = md;
    rc0 = r0;
    rc1 = 8'($random(seed));
    nData = 2'($random(seed));
    expInit = ini;
    expIdx = idx;
    frames = 0;
    dCnt = 0;
    t = 0;
    do begin
      @(negedge clock);
      t++;
    end while (resultValid !== 1'b1 && t < 8000);
    x = '0;
    x.initPhase = ini;
    x.index = 8'(idx);
    x.command = e.cmd;
    x.cls = clsOf(e.cmd);
    x.fail = md != 2'd0;
    if (md == 2'd0) begin
      x.cerr = r0;
      x.code = r0[6:0];
      x.codeKnown = !r0[7] && (r0[6:0] inside {7'h00, 7'h02, 7'h03, 7'h04,
        7'h05, 7'h07, 7'h10, 7'h20, 7'h40});
      x.fstat = r0[7] ? 8'h00 : rc1;
    end
    check(result, x);
    check(frames, md == 2'd0 ? 1 : cfg.retryCount + 1);
    if (md == 2'd0) check(dCnt, nData);
    check(operating, !ini || idx + 1 >= int'(cfg.numInit));
    if (!ini) check(runLed, 1'b1);
  endtask

  // main sequence
  initial begin
    seed = 93104;
    {errorCnt, nChecks, frames, dCnt, cyc, lastEnd} = '0;
    {inFrame, flashSeen, expInit, expIdx} = '0;
    cfg = '{autoPoll: 1'b1, numInit: 8'h03, numPoll: 8'h06,
            intervalMs: 16'h0002, timeoutMs: 16'h000a, retryCount: 3'h1,
            preambleCount: 5'h03};
    preExp = 5;
    for (int i = 0; i < 8; i++) begin
      initTab[i] = 61'({$random(seed), $random(seed)});
      pollTab[i] = 61'({$random(seed), $random(seed)});
      initTab[i].dataLen = 8'(i % 4);
      pollTab[i].dataLen = 8'((i + 1) % 4);
      if (i < 3) initTab[i].cmd = cmds[i];
      if (i < 6) pollTab[i].cmd = cmds[i + 3];
    end
    initTab[0].longFmt = 1'b1;
    pollTab[0].longFmt = 1'b0;
    pollTab[0].pollAddr = 4'h0;
    {mode, rc0, rc1, nData} = '0;
    reset = 1'b1;
    repeat (6) @(negedge clock);
    check({txValid, resultValid, runLed, operating, cmdInit, cmdSel},
          {4'h0, 1'b1, 8'h00});
    reset = 1'b0;
    runCmd(1'b1, 0, 2'd0, 8'h00);
    runCmd(1'b1, 1, 2'd1, 8'h00);
    runCmd(1'b1, 2, 2'd0, 8'hb8);
    for (int k = 0; k < 26; k++)
      runCmd(1'b0, k % 6, (k % 5 == 3) ? 2'd2 : (k % 7 == 5) ? 2'd3 : 2'd0,
             k < 22 ? codes[k % 11] : 8'($random(seed)));
    // second start: longest preamble, slow flash, polling off
    reset = 1'b1;
    cfg.preambleCount = 5'h19;
    cfg.numInit = 8'h01;
    cfg.intervalMs = 16'h0258;
    cfg.autoPoll = 1'b0;
    preExp = 20;
    @(negedge clock);
    reset = 1'b0;
    lastEnd = cyc;
    inFrame = 1'b0;
    flashSeen = 1'b0;
    runCmd(1'b1, 0, 2'd0, 8'h20);
    check(flashSeen, 1'b1);
    frames = 0;
    repeat (7000) @(negedge clock);
    check(frames, 0);
    check(runLed, 1'b1);
    testDone();
  end
endmodule // testbench
